// ==== hdl/pdrc_core.sv ====
// Power-down, standby, slew, power-up init and security control with APB registers
//
// Contract
// - With power-down enabled, either request pin high or both put the device in power-down.
// - While powered down all internal logic and enabled outputs are frozen.
// - While powered down other pin changes are ignored until the request returns low.
// - An enabled request pin is neither a logic input nor an output; its macrocell stays usable.
// - Power-down exists only when configured; otherwise request pins are ordinary pins.
// - With standby enabled, the device drops to standby when no logic activity happens.
// - Each macrocell has its own reduced-power setting.
// - Each output has its own slew control, slow by default.
// - After power-up reset all registers initialise and outputs take their buffer polarity.
// - A programmed security fuse blocks pattern readback but leaves the signature readable.
// - Outputs already high-impedance at power-down entry stay so throughout.
// - After the request goes low, outputs are valid again within one microsecond.
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module pdrc_core
  import pdrc_pkg::*;
#(
  parameter int NUM_PINS = 16,
  parameter int NUM_MC = 32,
  parameter int RESUME_CYC = 4,
  parameter int INIT_CYC = 16,
  parameter int IDLE_CYC = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pdrc_pkg::ADDR_W-1:0] paddr,
  input wire logic [pdrc_pkg::DATA_W-1:0] pwdata,
  output logic [pdrc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] core_in,
  output logic core_hold,
  input wire logic [NUM_PINS-1:0] core_out,
  input wire logic [NUM_PINS-1:0] core_oe,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe,
  output logic [NUM_PINS-1:0] pin_slew_fast,
  output logic [NUM_MC-1:0] mc_reduced,
  output logic low_power_standby,
  output logic powered_down
);

  localparam int WAKE_BOUND = PD_EXIT_MAX_CYC;
  pdrc_state_t state;
  logic [NUM_PINS-1:0] sync_in;
  logic [NUM_PINS-1:0] prev_in;
  logic [NUM_PINS-1:0] prev_core;
  logic [CNT_W-1:0] init_cnt;
  logic [CNT_W-1:0] res_cnt;
  logic [CNT_W-1:0] idle_cnt;
  logic pd_enable;
  logic standby_en;
  logic fuse;
  logic [NUM_PINS-1:0] out_pol;
  logic [SIG_W-1:0] signature;
  logic [DATA_W-1:0] pattern;
  logic pd_active;
  logic activity;
  logic apb_setup;
  logic apb_write;
  logic [DATA_W-1:0] next_prdata;
  logic next_pslverr;

  // Mask of pins taken over as power-down requests
  function automatic logic [NUM_PINS-1:0] pd_mask(input logic en);
    logic [NUM_PINS-1:0] m;
    m = '0;
    if (en) begin
      m[PD_A_PIN] = 1'b1;
      m[PD_B_PIN] = 1'b1;
    end
    return m;
  endfunction

  // Pins are asynchronous to mclk
  pdrc_sync #(
    .WIDTH(NUM_PINS)
  ) u_pin_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in(pin_in),
    .sync_out(sync_in)
  );

  // Either request alone suffices; disabled option leaves pins as logic
  assign pd_active = pd_enable && (sync_in[PD_A_PIN] || sync_in[PD_B_PIN]);
  // Freeze core in the same cycle the request is seen, not one later
  assign core_hold = (state != PDRC_RUN) || pd_active;
  assign powered_down = (state == PDRC_DOWN);

  // Sequencing of init, run, power-down and resume
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= PDRC_INIT;
    end else begin
      case (state)
        PDRC_INIT: begin
          if (init_cnt == CNT_W'(INIT_CYC - 1)) begin
            state <= PDRC_RUN;
          end
        end
        PDRC_RUN: begin
          if (pd_active) begin
            state <= PDRC_DOWN;
          end
        end
        PDRC_DOWN: begin
          if (!pd_active) begin
            state <= PDRC_RESUME;
          end
        end
        PDRC_RESUME: begin
          if (pd_active) begin
            state <= PDRC_DOWN;
          end else if (res_cnt == CNT_W'(RESUME_CYC - 1)) begin
            state <= PDRC_RUN;
          end
        end
        default: begin
          state <= PDRC_INIT;
        end
      endcase
    end
  end

  // Init delay after reset release
  always_ff @(posedge mclk) begin
    if (rst) begin
      init_cnt <= '0;
    end else if (state == PDRC_INIT) begin
      init_cnt <= init_cnt + CNT_W'(1);
    end
  end

  // Resume delay, restarted on each power-down
  always_ff @(posedge mclk) begin
    if (rst) begin
      res_cnt <= '0;
    end else if (state == PDRC_RESUME) begin
      res_cnt <= res_cnt + CNT_W'(1);
    end else begin
      res_cnt <= '0;
    end
  end

  // Input capture, blocked while powered down
  always_ff @(posedge mclk) begin
    if (rst) begin
      core_in <= '0;
    end else if (state != PDRC_DOWN && !pd_active) begin
      core_in <= sync_in & ~pd_mask(pd_enable);
    end
  end

  // Pin drivers: polarity at init, core in run, held otherwise so high-Z stays high-Z
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_out <= OUT_POL_RST[NUM_PINS-1:0];
      pin_oe <= '0;
    end else if (state == PDRC_INIT) begin
      pin_out <= out_pol;
      pin_oe <= ~pd_mask(pd_enable);
    end else if (state == PDRC_RUN && !pd_active) begin
      pin_out <= core_out;
      pin_oe <= core_oe & ~pd_mask(pd_enable);
    end
  end

  // Activity tracking for automatic standby
  always_ff @(posedge mclk) begin
    if (rst) begin
      prev_in <= '0;
      prev_core <= '0;
    end else begin
      prev_in <= sync_in;
      prev_core <= core_out;
    end
  end

  assign activity = (sync_in != prev_in) || (core_out != prev_core);

  // Idle count saturates; any transition restarts it
  always_ff @(posedge mclk) begin
    if (rst) begin
      idle_cnt <= '0;
    end else if (activity || state != PDRC_RUN) begin
      idle_cnt <= '0;
    end else if (idle_cnt != CNT_W'(IDLE_CYC)) begin
      idle_cnt <= idle_cnt + CNT_W'(1);
    end
  end

  // Standby flag leaves on the first transition
  always_ff @(posedge mclk) begin
    if (rst) begin
      low_power_standby <= 1'b0;
    end else begin
      low_power_standby <= standby_en && state == PDRC_RUN && !activity &&
                           idle_cnt >= CNT_W'(IDLE_CYC - 1);
    end
  end

  // APB phase decode; zero wait states
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite;
  assign pready = 1'b1;

  // Control register
  always_ff @(posedge mclk) begin
    if (rst) begin
      pd_enable <= CTRL_RST[CTRL_PD_EN_BIT];
      standby_en <= CTRL_RST[CTRL_SB_EN_BIT];
    end else if (apb_write && paddr == OFS_CTRL) begin
      pd_enable <= pwdata[CTRL_PD_EN_BIT];
      standby_en <= pwdata[CTRL_SB_EN_BIT];
    end
  end

  // Per-macrocell reduced power bits
  always_ff @(posedge mclk) begin
    if (rst) begin
      mc_reduced <= MC_REDUCED_RST[NUM_MC-1:0];
    end else if (apb_write && paddr == OFS_MC_REDUCED) begin
      mc_reduced <= pwdata[NUM_MC-1:0];
    end
  end

  // Per-output slew, cleared means slow
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_slew_fast <= SLEW_FAST_RST[NUM_PINS-1:0];
    end else if (apb_write && paddr == OFS_SLEW_FAST) begin
      pin_slew_fast <= pwdata[NUM_PINS-1:0];
    end
  end

  // Output buffer polarity used during init
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_pol <= OUT_POL_RST[NUM_PINS-1:0];
    end else if (apb_write && paddr == OFS_OUT_POL) begin
      out_pol <= pwdata[NUM_PINS-1:0];
    end
  end

  // Fuse is one-way: writing one programs it, zero is ignored
  always_ff @(posedge mclk) begin
    if (rst) begin
      fuse <= 1'b0;
    end else if (apb_write && paddr == OFS_SECURITY && pwdata[SEC_FUSE_BIT]) begin
      fuse <= 1'b1;
    end
  end

  // User signature stays writable and readable
  always_ff @(posedge mclk) begin
    if (rst) begin
      signature <= SIGNATURE_RST;
    end else if (apb_write && paddr == OFS_SIGNATURE) begin
      signature <= pwdata[SIG_W-1:0];
    end
  end

  // Pattern store; a secured part cannot be rewritten to probe it
  always_ff @(posedge mclk) begin
    if (rst) begin
      pattern <= PATTERN_RST;
    end else if (apb_write && paddr == OFS_PATTERN && !fuse) begin
      pattern <= pwdata;
    end
  end

  // Read mux evaluated in setup so prdata comes from a flop
  always_comb begin
    next_prdata = '0;
    next_pslverr = 1'b0;
    if (paddr == OFS_CTRL) begin
      next_prdata[CTRL_PD_EN_BIT] = pd_enable;
      next_prdata[CTRL_SB_EN_BIT] = standby_en;
    end else if (paddr == OFS_MC_REDUCED) begin
      next_prdata[NUM_MC-1:0] = mc_reduced;
    end else if (paddr == OFS_SLEW_FAST) begin
      next_prdata[NUM_PINS-1:0] = pin_slew_fast;
    end else if (paddr == OFS_OUT_POL) begin
      next_prdata[NUM_PINS-1:0] = out_pol;
    end else if (paddr == OFS_SECURITY) begin
      next_prdata[SEC_FUSE_BIT] = fuse;
    end else if (paddr == OFS_SIGNATURE) begin
      next_prdata[SIG_W-1:0] = signature;
    end else if (paddr == OFS_PATTERN) begin
      if (fuse) begin
        next_pslverr = !pwrite;
      end else begin
        next_prdata = pattern;
      end
    end else if (paddr == OFS_STATUS) begin
      next_prdata[STAT_DOWN_BIT] = powered_down;
      next_prdata[STAT_STANDBY_BIT] = low_power_standby;
      next_prdata[STAT_INIT_DONE_BIT] = (state != PDRC_INIT);
      next_prdata[STAT_RESUMING_BIT] = (state == PDRC_RESUME);
    end else begin
      next_pslverr = 1'b1; // Unmapped offset reads zero
    end
  end

  // Answer registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Assertions
  sequence s_down_two;
    state == PDRC_DOWN ##1 state == PDRC_DOWN;
  endsequence
  sequence s_run_req;
    state == PDRC_RUN && pd_active;
  endsequence
  a_pd_entry: assert property (@(posedge mclk) disable iff (rst)
    s_run_req |=> state == PDRC_DOWN && core_hold)
    else $error("power-down not entered on request");
  a_hold_outputs: assert property (@(posedge mclk) disable iff (rst)
    s_down_two |-> $stable(pin_out) && $stable(pin_oe))
    else $error("outputs changed while powered down");
  a_inputs_ignored: assert property (@(posedge mclk) disable iff (rst)
    s_down_two |-> $stable(core_in))
    else $error("pin input passed while powered down");
  a_pd_pin_masked: assert property (@(posedge mclk) disable iff (rst)
    state == PDRC_RUN && $past(state == PDRC_RUN) && $past(pd_enable) && pd_enable
    |-> !core_in[PD_A_PIN] && !core_in[PD_B_PIN] && !pin_oe[PD_A_PIN] && !pin_oe[PD_B_PIN])
    else $error("request pin used as logic pin");
  a_pd_disabled: assert property (@(posedge mclk) disable iff (rst)
    !pd_enable |=> state != PDRC_DOWN)
    else $error("power-down without the option");
  a_standby_gate: assert property (@(posedge mclk) disable iff (rst)
    low_power_standby |-> $past(standby_en) && $past(state == PDRC_RUN) && !$past(activity))
    else $error("standby without enable or with activity");
  a_slew_default: assert property (@(posedge mclk)
    $fell(rst) |-> pin_slew_fast == '0)
    else $error("slew not slow after reset");
  a_init_polarity: assert property (@(posedge mclk) disable iff (rst)
    state == PDRC_INIT && $past(state == PDRC_INIT) |-> pin_out == $past(out_pol))
    else $error("init output not at buffer polarity");
  a_fuse_blocks: assert property (@(posedge mclk) disable iff (rst)
    psel && penable && !pwrite && paddr == OFS_PATTERN && $past(fuse)
    |-> prdata == '0 && pslverr)
    else $error("pattern readable with fuse set");
  a_wake_bound: assert property (@(posedge mclk) disable iff (rst)
    $fell(state == PDRC_DOWN) ##1 !pd_active [*3] |-> ##[0:WAKE_BOUND] state == PDRC_RUN)
    else $error("outputs not valid in time after power-down");
  a_no_reinit: assert property (@(posedge mclk) disable iff (rst)
    state == PDRC_RESUME ##1 state == PDRC_RUN |-> $stable(pin_out) && $stable(pin_oe))
    else $error("state not resumed as held");
endmodule

// ==== include/pdrc_pkg.sv ====
// Shared constants, register map and state type of the power-down and reset control block
package pdrc_pkg;

  // APB bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MC_REDUCED = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SLEW_FAST = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_OUT_POL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_SECURITY = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SIGNATURE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PATTERN = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1c;

  // Field positions
  localparam int CTRL_PD_EN_BIT = 0;
  localparam int CTRL_SB_EN_BIT = 1;
  localparam int SEC_FUSE_BIT = 0;
  localparam int STAT_DOWN_BIT = 0;
  localparam int STAT_STANDBY_BIT = 1;
  localparam int STAT_INIT_DONE_BIT = 2;
  localparam int STAT_RESUMING_BIT = 3;
  localparam int SIG_W = 16;

  // Pin positions that serve as power-down requests when enabled
  localparam int PD_A_PIN = 0;
  localparam int PD_B_PIN = 1;

  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [DATA_W-1:0] MC_REDUCED_RST = 32'h0;
  localparam logic [DATA_W-1:0] SLEW_FAST_RST = 32'h0;
  localparam logic [DATA_W-1:0] OUT_POL_RST = 32'h0;
  localparam logic [SIG_W-1:0] SIGNATURE_RST = 16'h0;
  localparam logic [DATA_W-1:0] PATTERN_RST = 32'h0;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PD_EXIT_MAX_NS = 1000;
  localparam int PD_EXIT_MAX_CYC = PD_EXIT_MAX_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  // Power sequencing states, Gray along init, run, down, resume
  typedef enum logic [1:0] {
    PDRC_INIT = 2'b00,
    PDRC_RUN = 2'b01,
    PDRC_DOWN = 2'b11,
    PDRC_RESUME = 2'b10
  } pdrc_state_t;

endpackage

// ==== hdl/pdrc_sync.sv ====
// Two-flop synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ps
module pdrc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// ==== tb/pdrc_board.sv ====
// Board model that drives the two power-down request pins
`timescale 1ns/1ps
module pdrc_board (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmd_a,
  input wire logic cmd_b,
  output logic power_down_request_a = 1'h0,
  output logic power_down_request_b = 1'h0
);
  // Requests stay low through reset so the power-up sequence is not disturbed
  always @(posedge mclk) begin
    power_down_request_a <= !rst && cmd_a;
    power_down_request_b <= !rst && cmd_b;
  end
endmodule

// ==== tb/tb_pdrc_core.sv ====
// Self-checking bench for the power-down and reset control block
`timescale 1ns/1ps
module tb_pdrc_core;
  import pdrc_pkg::*;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, cmd_a = 1'h0, cmd_b = 1'h0;
  logic [ADDR_W-1:0] paddr = 8'h0;
  logic [DATA_W-1:0] pwdata = 32'h0, prdata, mc_reduced, v;
  logic [DATA_W-1:0] lf = 32'h121c2;
  logic pready, pslverr, core_hold, low_power_standby, powered_down;
  logic power_down_request_a, power_down_request_b;
  logic [13:0] pin_hi = 14'h0;
  logic [15:0] core_out = 16'h0, core_oe = 16'h0;
  logic [15:0] pin_in, core_in, pin_out, pin_oe, pin_slew_fast;
  logic [31:0] q_dat[$];
  logic q_err[$];
  int failures = 0, comparisons = 0, n;

  always #5 mclk = ~mclk;
  assign pin_in = {pin_hi, power_down_request_b, power_down_request_a};

  pdrc_board board (.mclk(mclk), .rst(rst), .cmd_a(cmd_a), .cmd_b(cmd_b),
    .power_down_request_a(power_down_request_a), .power_down_request_b(power_down_request_b));
  pdrc_core uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .core_in(core_in), .core_hold(core_hold), .core_out(core_out),
    .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe), .pin_slew_fast(pin_slew_fast),
    .mc_reduced(mc_reduced), .low_power_standby(low_power_standby),
    .powered_down(powered_down));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One APB transfer; for a read, d and e are the expected data and error
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) begin
      q_dat.push_back(d);
      q_err.push_back(e);
    end
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1) @(posedge mclk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Each completed read is matched against the oldest expectation
  always @(posedge mclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (q_dat.size() == 0) chk(32'h1, 32'h0, "unexpected read");
      else begin
        chk(prdata, q_dat.pop_front(), "read data");
        chk(32'(pslverr), 32'(q_err.pop_front()), "read error");
      end
    end
  end

  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    $display("MISMATCH t=%0t timeout", $time);
    final_report;
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'h0;
    // Power-up init: outputs show their polarity while core logic holds
    apb(1'h1, OFS_OUT_POL, {16'h0, lf[15:0]}, 1'h0);
    repeat (4) @(posedge mclk);
    chk(32'(pin_oe), 32'hffff, "init enable");
    chk(32'(pin_out), 32'(lf[15:0]), "init level");
    chk(32'(core_hold), 32'h1, "init hold");
    repeat (20) @(posedge mclk);
    for (int i = 0; i < 8; i++) apb(1'h0, 8'(4 * i),
      i == 7 ? 32'h4 : i == 3 ? {16'h0, lf[15:0]} : 32'h0, 1'h0);
    apb(1'h0, 8'h20, 32'h0, 1'h1);
    lf = lfsr(lf);
    apb(1'h1, OFS_MC_REDUCED, lf, 1'h0);
    apb(1'h1, OFS_SLEW_FAST, {16'h0, lf[31:16]}, 1'h0);
    apb(1'h0, OFS_MC_REDUCED, lf, 1'h0);
    @(posedge mclk);
    chk(mc_reduced, lf, "reduced power");
    chk(32'(pin_slew_fast), {16'h0, lf[31:16]}, "slew");
    // Feature off: the request pin is an ordinary input
    core_oe <= 16'hffff;
    cmd_a <= 1'h1;
    repeat (8) @(posedge mclk);
    chk(32'(powered_down), 32'h0, "no power-down when off");
    chk(32'(core_in[0]), 32'h1, "ordinary pin");
    cmd_a <= 1'h0;
    repeat (4) @(posedge mclk);
    apb(1'h1, OFS_CTRL, 32'h1, 1'h0);
    // Enter and leave power-down by each request pin and by both
    for (int m = 1; m < 4; m++) begin
      lf = lfsr(lf);
      v = lfsr(lf);
      core_out <= lf[15:0];
      core_oe <= lf[31:16];
      pin_hi <= v[13:0];
      repeat (4) @(posedge mclk);
      chk(32'(pin_oe), 32'(lf[31:16] & 16'hfffc), "request pins not outputs");
      chk(32'(core_in), 32'({v[13:0], 2'h0}), "request pins not inputs");
      cmd_a <= m[0];
      cmd_b <= m[1];
      repeat (5) @(posedge mclk);
      chk(32'(powered_down), 32'h1, "entered");
      core_out <= ~lf[15:0];
      core_oe <= 16'hffff;
      pin_hi <= ~v[13:0];
      repeat (6) @(posedge mclk);
      chk(32'(pin_out & 16'hfffc), 32'(lf[15:0] & 16'hfffc), "held outputs");
      chk(32'(pin_oe), 32'(lf[31:16] & 16'hfffc), "high-z kept");
      chk(32'(core_in), 32'({v[13:0], 2'h0}), "pins ignored");
      apb(1'h0, OFS_STATUS, 32'h5, 1'h0);
      cmd_a <= 1'h0;
      cmd_b <= 1'h0;
      n = 0;
      while ((powered_down !== 1'h0 || core_hold !== 1'h0) && n < PD_EXIT_MAX_CYC) begin
        @(posedge mclk);
        n++;
      end
      chk(32'(n < PD_EXIT_MAX_CYC), 32'h1, "exit time");
      repeat (2) @(posedge mclk);
      chk(32'(pin_out & 16'hfffc), 32'(~lf[15:0] & 16'hfffc), "resumed");
      chk(32'(core_in), 32'({~v[13:0], 2'h0}), "pins live");
    end
    apb(1'h0, OFS_CTRL, 32'h1, 1'h0);
    // Quiet inputs let the device drop to standby; activity wakes it
    apb(1'h1, OFS_CTRL, 32'h3, 1'h0);
    n = 0;
    while (low_power_standby !== 1'h1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    chk(32'(low_power_standby), 32'h1, "standby entered");
    apb(1'h0, OFS_STATUS, 32'h6, 1'h0);
    core_out <= ~core_out;
    repeat (3) @(posedge mclk);
    chk(32'(low_power_standby), 32'h0, "standby left");
    // Fuse blocks pattern readback but not the signature
    apb(1'h1, OFS_PATTERN, lf, 1'h0);
    apb(1'h1, OFS_SIGNATURE, v, 1'h0);
    apb(1'h0, OFS_PATTERN, lf, 1'h0);
    apb(1'h1, OFS_SECURITY, 32'h1, 1'h0);
    apb(1'h0, OFS_PATTERN, 32'h0, 1'h1);
    apb(1'h0, OFS_SIGNATURE, {16'h0, v[15:0]}, 1'h0);
    apb(1'h0, OFS_SECURITY, 32'h1, 1'h0);
    repeat (2) @(posedge mclk);
    final_report;
  end
endmodule
